// ---- eqd_cfg.svh ----
// timing, field positions and reset values for the diagnostic block
`ifndef EQD_CFG_SVH
`define EQD_CFG_SVH

`define EQD_CLK_HZ 32'h05F5_E100
`define EQD_SCL_MAX_HZ 32'h0006_1A80
`define EQD_SCL_MIN_CYC ((`EQD_CLK_HZ + `EQD_SCL_MAX_HZ - 32'h0000_0001) / `EQD_SCL_MAX_HZ)
`define EQD_STRAP_SETTLE 3'h4
`define EQD_SMB_ADDR_BASE 7'h3D
`define EQD_BOOST_MAX 6'h37
`define EQD_STAT_RESET 2'h0
`define EQD_INT_LOSA 2'h0
`define EQD_INT_LOSB 2'h1
`define EQD_INT_LOCKUP 2'h2
`define EQD_INT_LOCKDN 2'h3
`define EQD_T7_A 5'h06
`define EQD_T7_B 5'h05
`define EQD_T9_A 5'h08
`define EQD_T9_B 5'h04
`define EQD_T23_A 5'h16
`define EQD_T23_B 5'h11
`define EQD_T31_A 5'h1E
`define EQD_T31_B 5'h1B
`define EQD_HIST_FULL 5'h1F

`endif

// ---- eqd_diag_status.sv ----
// diagnostic patterns, status pin, interrupts and host-port straps
`timescale 1ns/100ps
`include "eqd_cfg.svh"

module eqd_diag_status #(
  parameter int NUM_OUT = 3,
  parameter int ERR_W = 16,
  parameter int MUTE_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire eqd_pkg::eqd_gen_ctl_s [NUM_OUT-1:0] genCtl,
  input wire logic [NUM_OUT-1:0] injectReq,
  output logic [NUM_OUT-1:0] genOut,
  output logic [NUM_OUT-1:0] genActive,
  input wire logic chkEnable,
  input wire eqd_pkg::eqd_pat_e chkPat,
  input wire logic rxBit,
  input wire logic errClear,
  output logic [ERR_W-1:0] errCount,
  output logic chkActive,
  input wire logic cdrLock,
  input wire logic carrierFound_n,
  input wire logic adaptDone,
  input wire logic signalLossPrimary,
  input wire logic signalLossSecondary,
  input wire logic loopOutSelect,
  input wire logic loopOutNegPolarity,
  input wire logic loopTermOk,
  output logic cableFault,
  input wire logic [1:0] statusFunc,
  input wire logic statusFuncLoad,
  output logic [1:0] statusFuncNow,
  input wire logic [3:0] intMask,
  input wire logic intStatusRead,
  output logic [3:0] intStatus,
  output logic statusPinOut,
  output logic statusPinOe,
  input wire logic [5:0] boostRaw,
  output logic [5:0] cableBoostIndex,
  input wire logic [MUTE_W-1:0] muteThreshold,
  input wire logic [MUTE_W-1:0] eqLength,
  output logic muteOutputs,
  input wire logic [1:0] modePin,
  input wire logic [1:0] strapA,
  input wire logic [1:0] strapB,
  output eqd_pkg::eqd_host_cfg_s hostCfg,
  input wire logic sclPin,
  output logic smbusRateError
);

  ////////////////////////////////////////////////////////////////////////
  // state of the main clock domain

  typedef struct packed {
    logic lockM;
    logic lock;
    logic lockP;
    logic cdM;
    logic cd;
    logic adM;
    logic ad;
    logic losAM;
    logic losA;
    logic losAP;
    logic losBM;
    logic losB;
    logic losBP;
    logic termM;
    logic term;
    logic sclM;
    logic scl;
    logic sclP;
    logic [8:0] sclCnt;
    logic rateErr;
    logic [3:0] intSt;
    logic [1:0] statSel;
    logic statAssert;
    logic fault;
    logic mute;
    logic [5:0] boost;
    eqd_pkg::eqd_cap_e cap;
    logic [2:0] capCnt;
    logic [1:0] modeM;
    logic [1:0] mode;
    logic [1:0] saM;
    logic [1:0] sa;
    logic [1:0] sbM;
    logic [1:0] sb;
    eqd_pkg::eqd_host_cfg_s host;
    logic [NUM_OUT-1:0] injTog;
    logic [ERR_W-1:0] errGM;
    logic [ERR_W-1:0] errG;
    logic [ERR_W-1:0] errBase;
    logic [ERR_W-1:0] errCnt;
    logic chkOn;
  } eqd_clk_s;

  ////////////////////////////////////////////////////////////////////////
  // state of the link clock domain

  typedef struct packed {
    logic [NUM_OUT-1:0] enM;
    logic [NUM_OUT-1:0] en;
    logic [NUM_OUT-1:0][1:0] patM;
    logic [NUM_OUT-1:0][1:0] pat;
    logic [NUM_OUT-1:0] injM;
    logic [NUM_OUT-1:0] injS;
    logic [NUM_OUT-1:0] injP;
    logic lockM;
    logic lock;
    logic chkEnM;
    logic chkEn;
    logic [1:0] chkPatM;
    logic [1:0] chkPatS;
    logic [4:0] fill;
    logic [30:0] hist;
    logic [ERR_W-1:0] errBin;
    logic [ERR_W-1:0] errGray;
  } eqd_link_s;

  eqd_clk_s cs;
  eqd_clk_s next_cs;
  eqd_link_s ls;
  eqd_link_s next_ls;

  logic [3:0] intEvent;
  logic assertNow;
  eqd_pkg::eqd_host_cfg_s hostNew;
  logic [ERR_W-1:0] errBinNow;
  logic chkRun;
  logic predicted;
  logic [NUM_OUT-1:0] genRun;
  logic [NUM_OUT-1:0] injPulse;

  ////////////////////////////////////////////////////////////////////////
  // main domain next state

  always_comb begin
    next_cs = cs;
    // pins and analog detector levels pass two flops first
    next_cs.lockM = cdrLock;
    next_cs.lock = cs.lockM;
    next_cs.lockP = cs.lock;
    next_cs.cdM = carrierFound_n;
    next_cs.cd = cs.cdM;
    next_cs.adM = adaptDone;
    next_cs.ad = cs.adM;
    next_cs.losAM = signalLossPrimary;
    next_cs.losA = cs.losAM;
    next_cs.losAP = cs.losA;
    next_cs.losBM = signalLossSecondary;
    next_cs.losB = cs.losBM;
    next_cs.losBP = cs.losB;
    next_cs.termM = loopTermOk;
    next_cs.term = cs.termM;
    next_cs.sclM = sclPin;
    next_cs.scl = cs.sclM;
    next_cs.sclP = cs.scl;
    next_cs.modeM = modePin;
    next_cs.mode = cs.modeM;
    next_cs.saM = strapA;
    next_cs.sa = cs.saM;
    next_cs.sbM = strapB;
    next_cs.sb = cs.sbM;

    // serial clock period watch, rising edge to rising edge
    if (cs.scl && !cs.sclP) begin
      if (cs.host.smbus) begin
        next_cs.rateErr = cs.sclCnt < 9'(`EQD_SCL_MIN_CYC - 1);
      end
      next_cs.sclCnt = '0;
    end else if (cs.sclCnt != '1) begin
      next_cs.sclCnt = cs.sclCnt + 9'h001;
    end

    // interrupt sources; a new event wins over a read in the same cycle
    intEvent = '0;
    intEvent[`EQD_INT_LOSA] = cs.losA && !cs.losAP;
    intEvent[`EQD_INT_LOSB] = cs.losB && !cs.losBP;
    intEvent[`EQD_INT_LOCKUP] = cs.lock && !cs.lockP;
    intEvent[`EQD_INT_LOCKDN] = !cs.lock && cs.lockP;
    next_cs.intSt = (cs.intSt & ~{4{intStatusRead}}) | intEvent;

    // cable fault only for the positive leg of an enabled loop output
    next_cs.fault = loopOutSelect && !loopOutNegPolarity
                    && !cs.term;

    if (statusFuncLoad) begin
      next_cs.statSel = statusFunc;
    end
    case (eqd_pkg::eqd_stat_e'(cs.statSel))
      eqd_pkg::ST_LOCK: assertNow = cs.lock;
      eqd_pkg::ST_CARRIER: assertNow = !cs.cd && cs.ad;
      eqd_pkg::ST_FAULT: assertNow = cs.fault;
      eqd_pkg::ST_INT: assertNow = |(cs.intSt & intMask);
      default: assertNow = 1'b0;
    endcase
    next_cs.statAssert = assertNow;

    if (boostRaw > `EQD_BOOST_MAX) begin
      next_cs.boost = `EQD_BOOST_MAX;
    end else begin
      next_cs.boost = boostRaw;
    end
    next_cs.mute = eqLength > muteThreshold;

    // host port roles decoded from the settled straps
    hostNew = '0;
    case (eqd_pkg::eqd_level_e'(cs.mode))
      eqd_pkg::LVL_H: begin
        hostNew.spi = 1'b1;
        hostNew.powerSave = 1'b1;
      end
      eqd_pkg::LVL_F: hostNew.spi = 1'b1;
      eqd_pkg::LVL_R: hostNew.reserved = 1'b1;
      eqd_pkg::LVL_L: hostNew.smbus = 1'b1;
      default: hostNew.reserved = 1'b1;
    endcase
    hostNew.addr = `EQD_SMB_ADDR_BASE + {3'h0, cs.sa, cs.sb};

    case (cs.cap)
      eqd_pkg::CAP_WAIT: begin
        if (cs.capCnt == `EQD_STRAP_SETTLE) begin
          next_cs.cap = eqd_pkg::CAP_DONE;
          next_cs.host = hostNew;
        end else begin
          next_cs.capCnt = cs.capCnt + 3'h1;
        end
      end
      eqd_pkg::CAP_DONE: next_cs.cap = eqd_pkg::CAP_DONE;
      default: next_cs.cap = eqd_pkg::CAP_WAIT;
    endcase

    // injection commands cross to the link as toggles
    next_cs.injTog = cs.injTog ^ injectReq;

    // error count arrives gray coded; clear rebases instead of resetting
    next_cs.errGM = ls.errGray;
    next_cs.errG = cs.errGM;
    errBinNow[ERR_W-1] = cs.errG[ERR_W-1];
    for (int i = ERR_W - 2; i >= 0; i--) begin
      errBinNow[i] = errBinNow[i+1] ^ cs.errG[i];
    end
    if (errClear) begin
      next_cs.errBase = errBinNow;
    end
    next_cs.errCnt = errBinNow - cs.errBase;
    next_cs.chkOn = chkEnable && cs.lock;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs <= '0;
      cs.statSel <= `EQD_STAT_RESET;
      cs.sclCnt <= '1;
      cs.termM <= 1'b1;
      cs.term <= 1'b1;
      cs.cap <= eqd_pkg::CAP_WAIT;
    end else begin
      cs <= next_cs;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: control crossing and the checker

  always_comb begin
    next_ls = ls;
    next_ls.lockM = cdrLock;
    next_ls.lock = ls.lockM;
    for (int i = 0; i < NUM_OUT; i++) begin
      next_ls.enM[i] = genCtl[i].enable;
      next_ls.patM[i] = genCtl[i].pat;
    end
    next_ls.en = ls.enM;
    next_ls.pat = ls.patM;
    next_ls.injM = cs.injTog;
    next_ls.injS = ls.injM;
    next_ls.injP = ls.injS;
    next_ls.chkEnM = chkEnable;
    next_ls.chkEn = ls.chkEnM;
    next_ls.chkPatM = chkPat;
    next_ls.chkPatS = ls.chkPatM;

    chkRun = ls.chkEn && ls.lock;
    predicted = eqd_pkg::eqd_prbs_fb(ls.hist,
                                     eqd_pkg::eqd_pat_e'(ls.chkPatS));
    next_ls.hist = {ls.hist[29:0], rxBit};
    if (!chkRun) begin
      next_ls.fill = '0;
    end else if (ls.fill != `EQD_HIST_FULL) begin
      // history must hold a full window before mismatches mean errors
      next_ls.fill = ls.fill + 5'h01;
    end else if (predicted != rxBit) begin
      next_ls.errBin = ls.errBin + {{(ERR_W-1){1'b0}}, 1'b1};
    end
    next_ls.errGray = next_ls.errBin ^ (next_ls.errBin >> 1);
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      ls <= '0;
    end else begin
      ls <= next_ls;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per output generators

  generate
    for (genvar g = 0; g < NUM_OUT; g++) begin : gen_lane
      assign genRun[g] = ls.en[g] && ls.lock;
      assign injPulse[g] = ls.injS[g] ^ ls.injP[g];
      eqd_prbs_gen u_gen (
        .linkClk(linkClk),
        .rst(rst),
        .enable(genRun[g]),
        .pat(eqd_pkg::eqd_pat_e'(ls.pat[g])),
        .inject(injPulse[g]),
        .genBit(genOut[g]),
        .active(genActive[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign errCount = cs.errCnt;
  assign chkActive = cs.chkOn;
  assign cableFault = cs.fault;
  assign statusFuncNow = cs.statSel;
  assign intStatus = cs.intSt;
  assign statusPinOut = 1'b0;
  assign statusPinOe = cs.statAssert;
  assign cableBoostIndex = cs.boost;
  assign muteOutputs = cs.mute;
  assign hostCfg = cs.host;
  assign smbusRateError = cs.rateErr;

endmodule // eqd_diag_status

// ---- eqd_diag_status_properties.sv ----
// port assertions for the diagnostic and status block
`timescale 1ns/100ps
module eqd_diag_status_checker #(
  parameter int NUM_OUT = 3,
  parameter int MUTE_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic cdrLock,
  input wire logic loopOutSelect,
  input wire logic loopOutNegPolarity,
  input wire logic loopTermOk,
  input wire logic cableFault,
  input wire logic [1:0] statusFuncNow,
  input wire logic [3:0] intMask,
  input wire logic intStatusRead,
  input wire logic [3:0] intStatus,
  input wire logic statusPinOut,
  input wire logic statusPinOe,
  input wire logic [5:0] boostRaw,
  input wire logic [5:0] cableBoostIndex,
  input wire logic [MUTE_W-1:0] muteThreshold,
  input wire logic [MUTE_W-1:0] eqLength,
  input wire logic muteOutputs,
  input wire logic [NUM_OUT-1:0] genActive,
  input wire logic chkActive,
  input wire eqd_pkg::eqd_host_cfg_s hostCfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_lockShown;
    (statusFuncNow == 2'h0 && $stable(cdrLock))[*4];
  endsequence
  sequence s_unterminated;
    (loopOutSelect && !loopOutNegPolarity && !loopTermOk)[*4];
  endsequence
  property p_lockPin;
    s_lockShown |-> statusPinOe == cdrLock;
  endproperty
  property p_openDrain;
    statusPinOut == 1'b0;
  endproperty
  property p_faultSet;
    s_unterminated |-> cableFault;
  endproperty
  property p_faultClear;
    loopTermOk[*4] |-> !cableFault;
  endproperty
  property p_intPin;
    (statusFuncNow == 2'h3 && (|(intStatus & intMask)))[*3] |-> statusPinOe;
  endproperty
  property p_sticky;
    |($past(intStatus) & ~intStatus) |-> $past(intStatusRead);
  endproperty
  property p_boost;
    $stable(boostRaw)[*3] |->
      cableBoostIndex == ((boostRaw > 6'h37) ? 6'h37 : boostRaw);
  endproperty
  property p_mute;
    ($stable(eqLength) && $stable(muteThreshold))[*2] |->
      muteOutputs == (eqLength > muteThreshold);
  endproperty
  property p_addr;
    hostCfg.smbus |->
      !hostCfg.spi && hostCfg.addr >= 7'h3D && hostCfg.addr <= 7'h4C;
  endproperty
  property p_chkLock;
    (!cdrLock)[*5] |-> !chkActive;
  endproperty
  property p_genLock;
    @(posedge linkClk) disable iff (rst) (!cdrLock)[*5] |-> genActive == '0;
  endproperty
  ////////////////////////////////////////////////////////////////////////
  a_lockPin: assert property (p_lockPin)
    else $error("status pin does not follow lock");
  a_openDrain: assert property (p_openDrain)
    else $error("status pin drives high");
  a_faultSet: assert property (p_faultSet)
    else $error("cable fault missing");
  a_faultClear: assert property (p_faultClear)
    else $error("cable fault stuck");
  a_intPin: assert property (p_intPin)
    else $error("interrupt pin not pulled");
  a_sticky: assert property (p_sticky)
    else $error("interrupt bit cleared without read");
  a_boost: assert property (p_boost)
    else $error("boost index wrong");
  a_mute: assert property (p_mute)
    else $error("mute decision wrong");
  a_addr: assert property (p_addr)
    else $error("host config address out of range");
  a_chkLock: assert property (p_chkLock)
    else $error("checker active without lock");
  a_genLock: assert property (p_genLock)
    else $error("generator active without lock");
endmodule // eqd_diag_status_checker

bind eqd_diag_status eqd_diag_status_checker #(.NUM_OUT(NUM_OUT),
  .MUTE_W(MUTE_W)) eqd_diag_status_checker_i (.clk, .rst, .linkClk,
  .cdrLock, .loopOutSelect, .loopOutNegPolarity, .loopTermOk, .cableFault,
  .statusFuncNow, .intMask, .intStatusRead, .intStatus, .statusPinOut,
  .statusPinOe, .boostRaw, .cableBoostIndex, .muteThreshold, .eqLength,
  .muteOutputs, .genActive, .chkActive, .hostCfg);

// ---- eqd_diag_status_tb.sv ----
// testbench for the diagnostic and status block
`timescale 1ns/100ps
module eqd_diag_status_tb;
  logic clk, rst, linkClk, chkEnable, errClear, chkActive, cdrLock;
  eqd_pkg::eqd_gen_ctl_s [2:0] genCtl;
  logic [2:0] injectReq, genOut, genActive;
  eqd_pkg::eqd_pat_e chkPat;
  logic [15:0] errCount;
  logic carrierFound_n, adaptDone, signalLossPrimary, signalLossSecondary;
  logic loopOutSelect, loopOutNegPolarity, loopTermOk, cableFault;
  logic [1:0] statusFunc, statusFuncNow, modePin, strapA, strapB;
  logic statusFuncLoad, intStatusRead, statusPinOut, statusPinOe;
  logic [3:0] intMask, intStatus;
  logic [5:0] boostRaw, cableBoostIndex;
  logic [7:0] muteThreshold, eqLength, writeByte;
  eqd_pkg::eqd_host_cfg_s hostCfg;
  logic sclPin, smbusRateError, sclRun, sclFast, muteOutputs;
  logic [5:0] bIn [4] = '{6'h00, 6'h37, 6'h38, 6'h3F};
  wire logic rxBit;
  int n_mismatch, checks;
  assign rxBit = genOut[0];
  eqd_diag_status eqd_diag_status_i (.clk, .rst, .linkClk, .genCtl,
    .injectReq, .genOut, .genActive, .chkEnable, .chkPat, .rxBit, .errClear,
    .errCount, .chkActive, .cdrLock, .carrierFound_n, .adaptDone,
    .signalLossPrimary, .signalLossSecondary, .loopOutSelect,
    .loopOutNegPolarity, .loopTermOk, .cableFault, .statusFunc,
    .statusFuncLoad, .statusFuncNow, .intMask, .intStatusRead, .intStatus,
    .statusPinOut, .statusPinOe, .boostRaw, .cableBoostIndex, .muteThreshold,
    .eqLength, .muteOutputs, .modePin, .strapA, .strapB, .hostCfg, .sclPin,
    .smbusRateError);
  eqd_host_model eqd_host_model_i (.clk, .run(sclRun), .fast(sclFast),
    .addr(hostCfg.addr), .scl(sclPin), .writeByte);
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #1;
    forever #15 linkClk = ~linkClk;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic setFunc(input logic [1:0] f);
    statusFunc = f;
    pulse(statusFuncLoad);
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, carrierFound_n, loopTermOk} = 3'b111;
    {genCtl, injectReq, chkEnable, errClear, cdrLock, adaptDone} = '0;
    {signalLossPrimary, signalLossSecondary, loopOutSelect} = '0;
    {loopOutNegPolarity, statusFunc, statusFuncLoad, intMask} = '0;
    {intStatusRead, boostRaw, muteThreshold, eqLength, sclRun} = '0;
    {modePin, strapA, strapB, sclFast} = 7'b00_10_11_0;
    chkPat = eqd_pkg::PAT_7;
    n_mismatch = 0;
    checks = 0;
    tick(5);
    rst = 1'b0;
    tick(10);
    check({statusFuncNow, statusPinOe}, 3'b000);
    check({hostCfg.smbus, hostCfg.spi, hostCfg.addr}, 9'h148);
    check(writeByte, 8'h90);
    cdrLock = 1'b1;
    tick(5);
    check(statusPinOe, 1'b1);
    cdrLock = 1'b0;
    tick(5);
    check(statusPinOe, 1'b0);
    setFunc(2'h1);
    carrierFound_n = 1'b0;
    tick(5);
    check(statusPinOe, 1'b0);
    adaptDone = 1'b1;
    tick(5);
    check(statusPinOe, 1'b1);
    setFunc(2'h2);
    loopOutSelect = 1'b1;
    loopTermOk = 1'b0;
    tick(5);
    check({cableFault, statusPinOe}, 2'b11);
    loopOutNegPolarity = 1'b1;
    tick(5);
    check(cableFault, 1'b0);
    {loopOutNegPolarity, loopOutSelect} = 2'b00;
    tick(5);
    check(cableFault, 1'b0);
    loopOutSelect = 1'b1;
    tick(5);
    check(cableFault, 1'b1);
    loopTermOk = 1'b1;
    tick(5);
    check({cableFault, statusPinOe}, 2'b00);
    setFunc(2'h3);
    intMask = 4'b0101;
    pulse(intStatusRead);
    tick(4);
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: signalLossPrimary = 1'b1;
        1: signalLossSecondary = 1'b1;
        2: cdrLock = 1'b1;
        default: cdrLock = 1'b0;
      endcase
      tick(10);
      check({intStatus, statusPinOe}, {4'h1 << i, intMask[i]});
      pulse(intStatusRead);
      tick(2);
      check({intStatus, statusPinOe}, 5'h00);
    end
    muteThreshold = 8'h20;
    foreach (bIn[i]) begin
      boostRaw = bIn[i];
      eqLength = 8'h1F + 8'(i);
      tick(4);
      check(cableBoostIndex, (bIn[i] > 6'h37) ? 6'h37 : bIn[i]);
      check(muteOutputs, i > 1);
    end
    genCtl[0] = '{1'b1, eqd_pkg::PAT_7};
    chkEnable = 1'b1;
    tick(20);
    check({genActive, chkActive}, 4'h0);
    cdrLock = 1'b1;
    for (int p = 0; p < 4; p++) begin
      genCtl[0] = '{1'b1, eqd_pkg::eqd_pat_e'(p)};
      chkPat = eqd_pkg::eqd_pat_e'(p);
      tick(400);
      pulse(errClear);
      tick(100);
      check({genActive, chkActive, errCount}, 20'h30000);
      injectReq[0] = 1'b1;
      tick(1);
      injectReq[0] = 1'b0;
      tick(150);
      check(errCount, 16'h0003);
    end
    sclRun = 1'b1;
    sclFast = 1'b1;
    tick(600);
    check(smbusRateError, 1'b1);
    sclFast = 1'b0;
    tick(600);
    check(smbusRateError, 1'b0);
    sclRun = 1'b0;
    {rst, modePin} = 3'b111;
    tick(5);
    rst = 1'b0;
    tick(10);
    check({statusFuncNow, hostCfg.smbus, hostCfg.spi, hostCfg.powerSave,
      hostCfg.reserved}, 6'h06);
    conclude();
  end
endmodule // eqd_diag_status_tb

// ---- eqd_host_model.sv ----
// host controller stand-in: serial clock source and write command byte
`timescale 1ns/100ps
module eqd_host_model (
  input wire logic clk,
  input wire logic run,
  input wire logic fast,
  input wire logic [6:0] addr,
  output logic scl,
  output logic [7:0] writeByte
);
  int cnt;
  assign writeByte = {addr, 1'b0};
  // clock rests high on its pull-up between frames
  initial begin
    scl = 1'b1;
    cnt = 0;
    forever begin
      @(negedge clk);
      cnt = run ? cnt + 1 : 0;
      if (!run) begin
        scl = 1'b1;
      end else if (cnt >= (fast ? 60 : 130)) begin
        scl = ~scl;
        cnt = 0;
      end
    end
  end
endmodule // eqd_host_model

// ---- eqd_pkg.sv ----
// shared types and the pattern feedback functions
`include "eqd_cfg.svh"
package eqd_pkg;

  typedef enum logic [1:0] {
    LVL_L = 2'h0,
    LVL_R = 2'h1,
    LVL_F = 2'h2,
    LVL_H = 2'h3
  } eqd_level_e;

  typedef enum logic [1:0] {
    PAT_7 = 2'h0,
    PAT_9 = 2'h1,
    PAT_23 = 2'h2,
    PAT_31 = 2'h3
  } eqd_pat_e;

  typedef enum logic [1:0] {
    ST_LOCK = 2'h0,
    ST_CARRIER = 2'h1,
    ST_FAULT = 2'h2,
    ST_INT = 2'h3
  } eqd_stat_e;

  typedef enum logic {
    CAP_WAIT = 1'b0,
    CAP_DONE = 1'b1
  } eqd_cap_e;

  typedef struct packed {
    logic enable;
    eqd_pat_e pat;
  } eqd_gen_ctl_s;

  typedef struct packed {
    logic smbus;
    logic spi;
    logic powerSave;
    logic reserved;
    logic [6:0] addr;
  } eqd_host_cfg_s;

  // next sequence bit from history, newest bit at index 0
  function automatic logic eqd_prbs_fb(input logic [30:0] h,
                                       input eqd_pat_e p);
    logic fb;
    fb = 1'b0;
    case (p)
      PAT_7: fb = h[`EQD_T7_A] ^ h[`EQD_T7_B];
      PAT_9: fb = h[`EQD_T9_A] ^ h[`EQD_T9_B];
      PAT_23: fb = h[`EQD_T23_A] ^ h[`EQD_T23_B];
      PAT_31: fb = h[`EQD_T31_A] ^ h[`EQD_T31_B];
      default: fb = 1'b0;
    endcase
    return fb;
  endfunction

  // false when the window that feeds the taps is all zero
  function automatic logic eqd_prbs_live(input logic [30:0] h,
                                         input eqd_pat_e p);
    logic live;
    live = 1'b0;
    case (p)
      PAT_7: live = |h[`EQD_T7_A:0];
      PAT_9: live = |h[`EQD_T9_A:0];
      PAT_23: live = |h[`EQD_T23_A:0];
      PAT_31: live = |h[`EQD_T31_A:0];
      default: live = 1'b0;
    endcase
    return live;
  endfunction

endpackage

// ---- eqd_prbs_gen.sv ----
// one output's pattern generator with single-bit error injection
`timescale 1ns/100ps
`include "eqd_cfg.svh"
module eqd_prbs_gen (
  input wire logic linkClk,
  input wire logic rst,
  input wire logic enable,
  input wire eqd_pkg::eqd_pat_e pat,
  input wire logic inject,
  output logic genBit,
  output logic active
);

  typedef struct packed {
    logic [30:0] lfsr;
    logic bitOut;
    logic active;
  } eqd_gen_state_s;

  eqd_gen_state_s state;
  eqd_gen_state_s next_state;
  logic newBit;

  always_comb begin
    next_state = state;
    newBit = eqd_pkg::eqd_prbs_fb(state.lfsr, pat);
    next_state.active = enable;
    if (!enable) begin
      next_state.lfsr = '1;
      next_state.bitOut = 1'b0;
    end else if (!eqd_pkg::eqd_prbs_live(state.lfsr, pat)) begin
      // a pattern change can leave the tap window dead; reseed it
      next_state.lfsr = '1;
    end else begin
      next_state.lfsr = {state.lfsr[29:0], newBit};
      // only the output is flipped, so the sequence itself is unharmed
      next_state.bitOut = newBit ^ inject;
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign genBit = state.bitOut;
  assign active = state.active;

endmodule // eqd_prbs_gen
